// >>> lockin_output_scaling.sv
// output scaling datapath: filter, offset, expand, displays, channel outputs
// assumes upstream samples on the same clock and a classic wishbone master
`timescale 1ns/1ps
module lockin_output_scaling #(
   parameter int DISP_DIV = scale_pkg::DISP_DIV
) (
   input  wire  logic               clk_i,
   input  wire  logic               rst_i,
   input  wire  logic               wb_cyc_i,
   input  wire  logic               wb_stb_i,
   input  wire  logic               wb_we_i,
   input  wire  logic [7:0]         wb_adr_i,
   input  wire  logic [31:0]        wb_dat_i,
   input  wire  logic [3:0]         wb_sel_i,
   output logic       [31:0]        wb_dat_o,
   output logic                     wb_ack_o,
   input  wire  logic               sample_valid_i,
   input  wire  logic signed [15:0] phase_detector_x_i,
   input  wire  logic signed [15:0] phase_detector_y_i,
   input  wire  logic signed [15:0] mag_r_i,
   input  wire  logic signed [15:0] phase_i,
   input  wire  logic signed [15:0] x_noise_i,
   input  wire  logic signed [15:0] y_noise_i,
   input  wire  logic [3:0][15:0]   aux_mv_i,
   input  wire  logic               ref_below_200hz_i,
   output logic signed [17:0]       rear_x_o,
   output logic signed [17:0]       rear_y_o,
   output logic signed [17:0]       first_channel_out_o,
   output logic signed [17:0]       second_channel_out_o,
   output logic signed [17:0]       first_channel_disp_o,
   output logic signed [17:0]       second_channel_disp_o,
   output logic [1:0]               offset_ind_o,
   output logic [1:0]               expand_ind_o,
   output logic [1:0]               ratio_ind_o
);
   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [5:0]                    tc_cfg;
      logic [1:0]                    reserve_cfg;
      logic [2:0][15:0]              offset_cfg;
      logic [2:0][1:0]               expand_cfg;
      logic [1:0][7:0]               chan_cfg;
      logic                          ack;
      logic [31:0]                   rdata;
      logic [49:0]                   acc_x;
      logic [49:0]                   acc_y;
      logic [17:0]                   rear_x;
      logic [17:0]                   rear_y;
      logic [16:0]                   tick_cnt;
      logic                          tick;
      logic [1:0][17:0]              disp;
      logic [1:0][17:0]              chout;
      logic [1:0]                    ind_off;
      logic [1:0]                    ind_exp;
      logic [1:0]                    ind_ratio;
      logic [1:0]                    neg;
      logic [1:0]                    div_done;
      scale_pkg::div_state_e [1:0]   dstate;
      logic [1:0][39:0]              quo;
      logic [1:0][16:0]              rem;
      logic [1:0][16:0]              dvs;
      logic [1:0][5:0]               dcnt;
   } state_s;

   state_s s_reg;
   state_s s_next;

   // ------------------------------------------------------------------
   // arithmetic helpers
   // ------------------------------------------------------------------
   function automatic logic signed [17:0] sat(input logic signed [39:0] v);
      if (v > 40'(scale_pkg::FS_CODE)) begin
         return scale_pkg::FS_CODE;
      end else if (v < -40'(scale_pkg::FS_CODE)) begin
         return -scale_pkg::FS_CODE;
      end
      return v[17:0];
   endfunction

   function automatic logic signed [17:0] off_code(input logic [15:0] cent);
      logic signed [31:0] p;
      p = 32'($signed(cent)) * scale_pkg::FS_WIDE;
      return 18'(p / scale_pkg::CENTI_FULL);
   endfunction

   function automatic logic [7:0] fac(input logic [1:0] code);
      unique case (code)
         scale_pkg::EXP_X10:  return scale_pkg::FAC_X10;
         scale_pkg::EXP_X100: return scale_pkg::FAC_X100;
         default:             return scale_pkg::FAC_X1;
      endcase
   endfunction

   function automatic logic signed [17:0] aux_code(input logic [15:0] mv);
      logic signed [31:0] p;
      p = 32'($signed(mv)) * scale_pkg::FS_WIDE;
      return 18'(p / scale_pkg::AUX_FS_MV);
   endfunction

   // ------------------------------------------------------------------
   // combinational next state
   // ------------------------------------------------------------------
   logic [5:0]  eff_tc;
   logic [31:0] wmask;
   logic        bus_go;

   always_comb begin
      logic signed [50:0]   diff;
      logic signed [17:0]   filt_x;
      logic signed [17:0]   filt_y;
      logic signed [17:0]   q;
      logic signed [17:0]   off;
      logic signed [19:0]   d;
      logic signed [39:0]   prod;
      logic [7:0]           f;
      logic [2:0]           src;
      logic [1:0]           rsel;
      logic                 scaled;
      logic signed [15:0]   den;
      logic [39:0]          mag;
      logic [16:0]          t;
      logic [17:0]          res;
      diff   = '0;
      filt_x = '0;
      filt_y = '0;
      q      = '0;
      off    = '0;
      d      = '0;
      prod   = '0;
      f      = '0;
      src    = '0;
      rsel   = '0;
      scaled = 1'b0;
      den    = '0;
      mag    = '0;
      t      = '0;
      res    = '0;
      s_next = s_reg;
      // time constant limits
      eff_tc = s_reg.tc_cfg;
      if (ref_below_200hz_i) begin
         if (eff_tc > scale_pkg::TC_SHIFT_LONG) eff_tc = scale_pkg::TC_SHIFT_LONG;
      end else if (eff_tc > scale_pkg::TC_SHIFT_NORMAL) begin
         eff_tc = scale_pkg::TC_SHIFT_NORMAL;
      end
      if (s_reg.reserve_cfg == scale_pkg::RESERVE_VERY_HIGH &&
          eff_tc < scale_pkg::TC_SHIFT_MIN_HIGH) begin
         eff_tc = scale_pkg::TC_SHIFT_MIN_HIGH;
      end
      // exponential averaging, one step per incoming sample
      if (sample_valid_i) begin
         diff = (51'(phase_detector_x_i) <<< scale_pkg::FRAC_BITS) - 51'($signed(s_reg.acc_x));
         s_next.acc_x = 50'($signed(s_reg.acc_x) + (diff >>> eff_tc));
         diff = (51'(phase_detector_y_i) <<< scale_pkg::FRAC_BITS) - 51'($signed(s_reg.acc_y));
         s_next.acc_y = 50'($signed(s_reg.acc_y) + (diff >>> eff_tc));
      end
      // dc gain after detection tracks the reserve setting
      filt_x = sat(40'($signed(s_reg.acc_x) >>> scale_pkg::FRAC_BITS) <<< s_reg.reserve_cfg);
      filt_y = sat(40'($signed(s_reg.acc_y) >>> scale_pkg::FRAC_BITS) <<< s_reg.reserve_cfg);
      // rear outputs: recomputed every clock, far above the 100 khz band
      d = 20'(filt_x) - 20'(off_code(s_reg.offset_cfg[0]));
      s_next.rear_x = sat(40'(d) * 40'(fac(s_reg.expand_cfg[0])));
      d = 20'(filt_y) - 20'(off_code(s_reg.offset_cfg[1]));
      s_next.rear_y = sat(40'(d) * 40'(fac(s_reg.expand_cfg[1])));
      // display refresh divider
      s_next.tick = 1'b0;
      s_next.tick_cnt = s_reg.tick_cnt + 17'h00001;
      if (s_reg.tick_cnt == 17'(DISP_DIV - 1)) begin
         s_next.tick_cnt = '0;
         s_next.tick = 1'b1;
      end
      // per-channel display path
      for (int c = 0; c < 2; c++) begin
         src    = s_reg.chan_cfg[c][2:0];
         rsel   = s_reg.chan_cfg[c][scale_pkg::CHAN_RATIO_LSB +: 2];
         scaled = 1'b0;
         off    = '0;
         f      = scale_pkg::FAC_X1;
         unique case (src)
            scale_pkg::SRC_MAIN: begin
               q = (c == 0) ? filt_x : filt_y;
               off = off_code(s_reg.offset_cfg[c]);
               f = fac(s_reg.expand_cfg[c]);
               scaled = 1'b1;
            end
            scale_pkg::SRC_ALT: begin
               if (c == 0) begin
                  q = sat(40'(mag_r_i));
                  off = off_code(s_reg.offset_cfg[2]);
                  f = fac(s_reg.expand_cfg[2]);
                  scaled = 1'b1;
               end else begin
                  q = 18'(phase_i >>> scale_pkg::PHASE_SHIFT);
               end
            end
            scale_pkg::SRC_NOISE: q = (c == 0) ? 18'(x_noise_i) : 18'(y_noise_i);
            scale_pkg::SRC_AUX_A: q = aux_code(aux_mv_i[2 * c]);
            scale_pkg::SRC_AUX_B: q = aux_code(aux_mv_i[2 * c + 1]);
            default:              q = '0;
         endcase
         d = 20'(q) - 20'(off);
         den = (rsel == scale_pkg::RATIO_B) ? aux_mv_i[2 * c + 1] : aux_mv_i[2 * c];
         if (s_reg.tick) begin
            s_next.ind_off[c] = scaled && off != '0;
            s_next.ind_exp[c] = scaled && f != scale_pkg::FAC_X1;
            s_next.ind_ratio[c] = rsel == scale_pkg::RATIO_A || rsel == scale_pkg::RATIO_B;
            if (rsel == scale_pkg::RATIO_A || rsel == scale_pkg::RATIO_B) begin
               prod = 40'(d) * 40'(f) * 40'(scale_pkg::MV_PER_V);
               s_next.neg[c] = prod[39] ^ den[15];
               s_next.quo[c] = prod[39] ? -prod : prod;
               s_next.dvs[c] = den[15] ? -17'(den) : 17'(den);
               s_next.rem[c] = '0;
               s_next.dcnt[c] = scale_pkg::DIV_STEPS;
               s_next.dstate[c] = scale_pkg::DIV_RUN;
            end else begin
               s_next.disp[c] = sat(40'(d));
               s_next.chout[c] = scaled ? sat(40'(d) * 40'(f)) : sat(40'(d));
            end
         end
         s_next.div_done[c] = 1'b0;
         unique case (s_reg.dstate[c])
            scale_pkg::DIV_IDLE: ;
            scale_pkg::DIV_RUN: begin
               if (s_reg.dcnt[c] != '0) begin
                  t = {s_reg.rem[c][15:0], s_reg.quo[c][39]};
                  if (t >= s_reg.dvs[c]) begin
                     s_next.rem[c] = t - s_reg.dvs[c];
                     s_next.quo[c] = {s_reg.quo[c][38:0], 1'b1};
                  end else begin
                     s_next.rem[c] = t;
                     s_next.quo[c] = {s_reg.quo[c][38:0], 1'b0};
                  end
                  s_next.dcnt[c] = s_reg.dcnt[c] - 6'h01;
               end else begin
                  // a zero divisor gives all ones, which clamps below
                  mag = s_reg.quo[c];
                  res = (mag > 40'(scale_pkg::FS_CODE)) ? scale_pkg::FS_CODE : mag[17:0];
                  s_next.disp[c] = s_reg.neg[c] ? -res : res;
                  s_next.chout[c] = s_reg.neg[c] ? -res : res;
                  s_next.div_done[c] = 1'b1;
                  s_next.dstate[c] = scale_pkg::DIV_IDLE;
               end
            end
         endcase
         if (s_reg.chan_cfg[c][scale_pkg::CHAN_DIRECT_BIT]) begin
            s_next.chout[c] = (c == 0) ? s_next.rear_x : s_next.rear_y;
         end
      end
      // wishbone slave, one wait state, ack for one cycle
      bus_go = wb_cyc_i && wb_stb_i && !s_reg.ack;
      s_next.ack = bus_go;
      wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      if (bus_go && wb_we_i) begin
         unique case (wb_adr_i)
            scale_pkg::REG_FILTER: begin
               if (wb_sel_i[0]) s_next.tc_cfg = wb_dat_i[5:0];
               if (wb_sel_i[1]) begin
                  s_next.reserve_cfg = wb_dat_i[scale_pkg::FILTER_RES_LSB +: 2];
               end
            end
            scale_pkg::REG_X_OFFSET, scale_pkg::REG_Y_OFFSET, scale_pkg::REG_R_OFFSET: begin
               q = 18'($signed((wb_dat_i[15:0] & wmask[15:0]) |
                   (s_reg.offset_cfg[wb_adr_i[3:2] - 2'h1] & ~wmask[15:0])));
               // out of range writes clamp so the stored percent stays legal
               if (q > 18'(scale_pkg::OFFSET_LIMIT)) q = 18'(scale_pkg::OFFSET_LIMIT);
               if (q < -18'(scale_pkg::OFFSET_LIMIT)) q = -18'(scale_pkg::OFFSET_LIMIT);
               s_next.offset_cfg[wb_adr_i[3:2] - 2'h1] = q[15:0];
            end
            scale_pkg::REG_EXPAND: if (wb_sel_i[0]) s_next.expand_cfg = wb_dat_i[5:0];
            scale_pkg::REG_CHANNEL: begin
               if (wb_sel_i[0]) s_next.chan_cfg[0] = wb_dat_i[7:0];
               if (wb_sel_i[1]) s_next.chan_cfg[1] = wb_dat_i[15:8];
            end
            default: ;
         endcase
      end
      s_next.rdata = '0;
      if (bus_go && !wb_we_i) begin
         unique case (wb_adr_i)
            scale_pkg::REG_FILTER:      s_next.rdata = {22'h0, s_reg.reserve_cfg, 2'h0, s_reg.tc_cfg};
            scale_pkg::REG_X_OFFSET:    s_next.rdata = {16'h0, s_reg.offset_cfg[0]};
            scale_pkg::REG_Y_OFFSET:    s_next.rdata = {16'h0, s_reg.offset_cfg[1]};
            scale_pkg::REG_R_OFFSET:    s_next.rdata = {16'h0, s_reg.offset_cfg[2]};
            scale_pkg::REG_EXPAND:      s_next.rdata = {26'h0, s_reg.expand_cfg};
            scale_pkg::REG_CHANNEL:     s_next.rdata = {16'h0, s_reg.chan_cfg};
            scale_pkg::REG_STATUS:      s_next.rdata = {18'h0, s_reg.ind_ratio, s_reg.ind_exp,
                                                        s_reg.ind_off, 2'h0, eff_tc};
            scale_pkg::REG_FIRST_DISP:  s_next.rdata = 32'($signed(s_reg.disp[0]));
            scale_pkg::REG_SECOND_DISP: s_next.rdata = 32'($signed(s_reg.disp[1]));
            default:                    s_next.rdata = '0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // register stage
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg             <= '0;
         s_reg.tc_cfg      <= scale_pkg::TC_RESET;
         s_reg.offset_cfg  <= {3{scale_pkg::OFFSET_RESET}};
         s_reg.chan_cfg    <= {2{scale_pkg::CHAN_RESET}};
         s_reg.dstate[0]   <= scale_pkg::DIV_IDLE;
         s_reg.dstate[1]   <= scale_pkg::DIV_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign wb_dat_o              = s_reg.rdata;
   assign wb_ack_o              = s_reg.ack;
   assign rear_x_o              = s_reg.rear_x;
   assign rear_y_o              = s_reg.rear_y;
   assign first_channel_out_o   = s_reg.chout[0];
   assign second_channel_out_o  = s_reg.chout[1];
   assign first_channel_disp_o  = s_reg.disp[0];
   assign second_channel_disp_o = s_reg.disp[1];
   assign offset_ind_o          = s_reg.ind_off;
   assign expand_ind_o          = s_reg.ind_exp;
   assign ratio_ind_o           = s_reg.ind_ratio;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_ack_single;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");

   property p_rear_bound;
      $signed(rear_x_o) <= scale_pkg::FS_CODE && $signed(rear_x_o) >= -scale_pkg::FS_CODE;
   endproperty
   a_rear_bound: assert property (p_rear_bound) else $error("rear x beyond full scale");

   property p_offset_range;
      $signed(s_reg.offset_cfg[2]) <= scale_pkg::OFFSET_LIMIT &&
      $signed(s_reg.offset_cfg[2]) >= -scale_pkg::OFFSET_LIMIT;
   endproperty
   a_offset_range: assert property (p_offset_range) else $error("r offset out of range");

   property p_tc_limit;
      !ref_below_200hz_i |-> eff_tc <= scale_pkg::TC_SHIFT_NORMAL;
   endproperty
   a_tc_limit: assert property (p_tc_limit) else $error("long time constant allowed");

   property p_tc_min;
      s_reg.reserve_cfg == scale_pkg::RESERVE_VERY_HIGH |-> eff_tc >= scale_pkg::TC_SHIFT_MIN_HIGH;
   endproperty
   a_tc_min: assert property (p_tc_min) else $error("short time constant at high reserve");

   property p_direct_copy;
      s_reg.chan_cfg[0][scale_pkg::CHAN_DIRECT_BIT] ##1
      s_reg.chan_cfg[0][scale_pkg::CHAN_DIRECT_BIT] |-> first_channel_out_o == rear_x_o;
   endproperty
   a_direct_copy: assert property (p_direct_copy) else $error("direct output differs");

   property p_display_rate;
      !s_reg.chan_cfg[1][scale_pkg::CHAN_DIRECT_BIT] &&
      !$past(s_reg.chan_cfg[1][scale_pkg::CHAN_DIRECT_BIT]) &&
      second_channel_out_o != $past(second_channel_out_o)
      |-> $past(s_reg.tick) || s_reg.div_done[1];
   endproperty
   a_display_rate: assert property (p_display_rate) else $error("display output off tick");

   property p_ratio_ind;
      s_reg.tick |=> ratio_ind_o[0] ==
         ($past(s_reg.chan_cfg[0][4:3]) == scale_pkg::RATIO_A ||
          $past(s_reg.chan_cfg[0][4:3]) == scale_pkg::RATIO_B);
   endproperty
   a_ratio_ind: assert property (p_ratio_ind) else $error("ratio indicator wrong");

   property p_phase_scale;
      s_reg.tick && s_reg.chan_cfg[1][5:0] == {3'h0, scale_pkg::SRC_ALT}
      |=> $signed(second_channel_disp_o) == ($past(phase_i) >>> scale_pkg::PHASE_SHIFT);
   endproperty
   a_phase_scale: assert property (p_phase_scale) else $error("phase scale wrong");

   property p_ratio_limit;
      s_reg.div_done[0] |-> $signed(first_channel_disp_o) <= scale_pkg::FS_CODE &&
                            $signed(first_channel_disp_o) >= -scale_pkg::FS_CODE;
   endproperty
   a_ratio_limit: assert property (p_ratio_limit) else $error("ratio above 100 percent");
endmodule // lockin_output_scaling

// >>> scale_pkg.sv
// constants shared by the output scaling datapath
// assumes a 50 MHz system clock and a 32-bit classic wishbone master
package scale_pkg;
   // ------------------------------------------------------------------
   // fixed point: full scale (10 V, 180 deg) is 2^14 codes
   // ------------------------------------------------------------------
   localparam logic signed [17:0] FS_CODE       = 18'sh04000;
   localparam logic signed [31:0] FS_WIDE       = 32'sh00004000;
   localparam logic signed [31:0] CENTI_FULL    = 32'sh00002710;
   localparam logic signed [15:0] OFFSET_LIMIT  = 16'sh2904;
   localparam logic signed [31:0] AUX_FS_MV     = 32'sh00002710;
   localparam logic        [10:0] MV_PER_V      = 11'h3e8;
   localparam int                 PHASE_SHIFT   = 1;
   localparam int                 FRAC_BITS     = 34;
   // ------------------------------------------------------------------
   // expand and source encodings
   // ------------------------------------------------------------------
   localparam logic [1:0] EXP_X10   = 2'h1;
   localparam logic [1:0] EXP_X100  = 2'h2;
   localparam logic [7:0] FAC_X1    = 8'h01;
   localparam logic [7:0] FAC_X10   = 8'h0a;
   localparam logic [7:0] FAC_X100  = 8'h64;
   localparam logic [2:0] SRC_MAIN  = 3'h0;
   localparam logic [2:0] SRC_ALT   = 3'h1;
   localparam logic [2:0] SRC_NOISE = 3'h2;
   localparam logic [2:0] SRC_AUX_A = 3'h3;
   localparam logic [2:0] SRC_AUX_B = 3'h4;
   localparam logic [1:0] RATIO_A   = 2'h1;
   localparam logic [1:0] RATIO_B   = 2'h2;
   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int          CLK_HZ      = 50000000;
   localparam int          DISP_HZ     = 512;
   localparam int          DISP_DIV    = CLK_HZ / DISP_HZ;
   localparam int          SAMPLE_HZ   = 256000;
   localparam longint      TC_LONG_S   = 30000;
   localparam logic [5:0]  TC_SHIFT_LONG = 6'($clog2(TC_LONG_S * SAMPLE_HZ));
   localparam logic [5:0]  TC_SHIFT_NORMAL   = 6'h17;
   localparam logic [5:0]  TC_SHIFT_MIN_HIGH = 6'h04;
   localparam logic [1:0]  RESERVE_VERY_HIGH = 2'h3;
   localparam logic [5:0]  DIV_STEPS         = 6'h28;
   // ------------------------------------------------------------------
   // register map and fields
   // ------------------------------------------------------------------
   localparam logic [7:0] REG_FILTER      = 8'h00;
   localparam logic [7:0] REG_X_OFFSET    = 8'h04;
   localparam logic [7:0] REG_Y_OFFSET    = 8'h08;
   localparam logic [7:0] REG_R_OFFSET    = 8'h0c;
   localparam logic [7:0] REG_EXPAND      = 8'h10;
   localparam logic [7:0] REG_CHANNEL     = 8'h14;
   localparam logic [7:0] REG_STATUS      = 8'h18;
   localparam logic [7:0] REG_FIRST_DISP  = 8'h1c;
   localparam logic [7:0] REG_SECOND_DISP = 8'h20;
   localparam int         FILTER_RES_LSB  = 8;
   localparam int         CHAN_RATIO_LSB  = 3;
   localparam int         CHAN_DIRECT_BIT = 5;
   localparam logic [5:0] TC_RESET        = 6'h08;
   localparam logic [15:0] OFFSET_RESET   = 16'h0000;
   localparam logic [7:0] CHAN_RESET      = 8'h00;
   typedef enum logic {DIV_IDLE, DIV_RUN} div_state_e;
endpackage

// >>> lockin_dac_model.sv
// far side model: output converter turning an 18-bit code into millivolts
// assumes codes where 16384 is full scale, sampled on the system clock
`timescale 1ns/1ps
module lockin_dac_model (
   input  wire logic               clk_i,
   input  wire logic signed [17:0] level_i,
   output int                      mv_o
);
   // integer division truncates toward zero, as a real converter would not
   always @(posedge clk_i) mv_o <= level_i * 10000 / 16384;
endmodule // lockin_dac_model

// >>> lockin_output_scaling_tb_top.sv
// self-checking bench for the output scaling datapath
// assumes one 50 MHz clock and a classic wishbone slave answering in one cycle
`timescale 1ns/1ps
module lockin_output_scaling_tb_top;
   localparam int DD = 64;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sv = 0, rb = 0, ack;
   logic [7:0] adr = 0;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 0, q, dato;
   logic signed [15:0] x = 0, y = 0, r = 0, p = 0, nx = 0, ny = 0;
   logic [3:0][15:0] aux = '0;
   logic signed [17:0] rx, ry, c1, c2, d1, d2;
   logic [1:0] oi, ei, ri;
   int mv, e, fail_count = 0, check_count = 0, n = 0;
   int unsigned s = 22094;
   lockin_output_scaling #(.DISP_DIV(DD)) lockin_output_scaling_i (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat),
      .wb_sel_i(sel), .wb_dat_o(dato), .wb_ack_o(ack), .sample_valid_i(sv),
      .phase_detector_x_i(x), .phase_detector_y_i(y), .mag_r_i(r), .phase_i(p),
      .x_noise_i(nx), .y_noise_i(ny), .aux_mv_i(aux), .ref_below_200hz_i(rb),
      .rear_x_o(rx), .rear_y_o(ry), .first_channel_out_o(c1), .second_channel_out_o(c2),
      .first_channel_disp_o(d1), .second_channel_disp_o(d2), .offset_ind_o(oi),
      .expand_ind_o(ei), .ratio_ind_o(ri));
   lockin_dac_model lockin_dac_model_i (.clk_i(clk_i), .level_i(c1), .mv_o(mv));
   initial forever #10 clk_i = ~clk_i;
   function automatic int unsigned rnd();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic int sat(int v);
      return v > 16384 ? 16384 : (v < -16384 ? -16384 : v);
   endfunction
   // ratio code: value times expand times 1000 over aux millivolts, zero aux clamps
   function automatic int rq(int v, int a);
      if (a == 0) return v < 0 ? -16384 : 16384;
      return sat(v / a);
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] w);
      check_count++;
      if (g !== w) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, w);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
      sel <= 4'hf;
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dato;
      cyc <= 0; stb <= 0;
      @(posedge clk_i);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard: the sequence needs under 3000 cycles
   always @(posedge clk_i) begin
      n++;
      if (n == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 0;
      wb(0, scale_pkg::REG_FILTER, 0);
      chk(q[5:0], scale_pkg::TC_RESET);
      wb(0, 8'h40, 0);
      chk(q, 0);
      wb(1, scale_pkg::REG_FILTER, 0);
      wb(1, scale_pkg::REG_X_OFFSET, 5000);
      wb(1, scale_pkg::REG_EXPAND, 1);
      wb(0, scale_pkg::REG_X_OFFSET, 0);
      chk(q, 5000);
      repeat (8) begin
         @(posedge clk_i);
         x <= 16'(rnd() & 32'h3fff); y <= 16'(rnd()); r <= 16'(rnd()); p <= 16'(rnd());
         nx <= 16'(rnd()); ny <= 16'(rnd()); aux <= {rnd(), rnd()}; rb <= 1'(rnd()); sv <= 1;
         @(posedge clk_i);
         sv <= 0;
         repeat (2 * DD) @(posedge clk_i);
         e = sat((x - 8192) * 10);
         chk(rx, e);
         chk(ry, sat(y));
         chk(c1, e);
         chk(d1, x - 8192);
         chk(d2, sat(y));
         chk({ei, oi, ri}, 6'b010100);
         chk(mv, e * 10000 / 16384);
      end
      // r with its own offset and expand, phase display, direct first output
      wb(1, scale_pkg::REG_R_OFFSET, 2500);
      wb(1, scale_pkg::REG_EXPAND, 32'h20);
      wb(1, scale_pkg::REG_CHANNEL, 32'h0121);
      @(posedge clk_i);
      r <= 16'(rnd());
      p <= 16'(rnd());
      repeat (2 * DD) @(posedge clk_i);
      chk(rx, x - 8192);
      chk(c1, x - 8192);
      chk(d1, sat(sat(r) - 4096));
      chk(d2, (p * 16384) >>> 15);
      chk(c2, (p * 16384) >>> 15);
      chk({ei, oi, ri}, 6'b010100);
      // ratio displays: x over aux 1, aux 3 over aux 4
      wb(1, scale_pkg::REG_CHANNEL, 32'h1308);
      repeat (4) begin
         @(posedge clk_i);
         aux <= {rnd(), rnd()};
         repeat (2 * DD) @(posedge clk_i);
         e = rq((x - 8192) * 1000, $signed(aux[0]));
         chk(d1, e);
         chk(c1, e);
         chk(mv, e * 10000 / 16384);
         chk(d2, rq($signed(aux[2]) * 16384 / 10000 * 1000, $signed(aux[3])));
         chk({ei, oi, ri}, 6'b000111);
      end
      wb(0, scale_pkg::REG_STATUS, 0);
      chk(q, 32'h3100);
      rb <= 1'b0;
      wb(1, scale_pkg::REG_FILTER, 32'h3f);
      wb(0, scale_pkg::REG_STATUS, 0);
      chk(q[5:0], scale_pkg::TC_SHIFT_NORMAL);
      wb(1, scale_pkg::REG_FILTER, 32'h0302);
      wb(0, scale_pkg::REG_STATUS, 0);
      chk(q[5:0], scale_pkg::TC_SHIFT_MIN_HIGH);
      give_verdict();
   end
endmodule // lockin_output_scaling_tb_top
